// ---- src/dfc_pkg.sv ----
// dfc_pkg: register map, field layout and code constants of the fault code reporter
// assumes a single 40 MHz core clock domain and a 32-bit ahb-lite register bus
package dfc_pkg;

  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [7:0] DFC_REG_EVENT = 8'h00;
  localparam logic [7:0] DFC_REG_CAUSE = 8'h04;
  localparam logic [7:0] DFC_REG_AUX = 8'h08;
  localparam logic [7:0] DFC_REG_STATUS = 8'h0C;
  localparam logic [7:0] DFC_REG_ACK = 8'h10;
  localparam logic [7:0] DFC_REG_DRVSTAT = 8'h14;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int DFC_CODE_LSB = 0;
  localparam int DFC_AUXA_LSB = 8;
  localparam int DFC_AUXB_LSB = 16;
  localparam int DFC_LOG_LSB = 24;
  localparam int DFC_VALID_BIT = 26;
  localparam int DFC_CAUSE_LSB = 0;
  localparam int DFC_OP_WRITE_BIT = 8;
  localparam int DFC_UNRECOV_BIT = 9;
  localparam int DFC_CORRECTED_BIT = 10;
  localparam int DFC_FIRE_BIT = 31;
  localparam int DFC_ACK_BIT = 0;
  localparam logic [7:0] DFC_CODE_RESET = 8'h00;

  // ****************************************
  // timing: power-on wait for command complete
  // ****************************************
  localparam int DFC_CLK_HZ = 40000000;
  localparam int DFC_PON_WAIT_S = 30;
  localparam longint DFC_PON_WAIT_CYC = longint'(DFC_PON_WAIT_S) * longint'(DFC_CLK_HZ);

  // ****************************************
  // log kind and supporting status source
  // ****************************************
  typedef enum logic [1:0] {
    DFC_LOG_NONE,
    DFC_LOG_RUN,
    DFC_LOG_FAULT
  } dfc_log_t;

  typedef enum logic [1:0] {
    DFC_AUX_NONE,
    DFC_AUX_DRIVE,
    DFC_AUX_CTRL
  } dfc_aux_t;

  // ****************************************
  // condition causes (software or hardware)
  // ****************************************
  typedef enum logic [4:0] {
    DFC_C_DATA_FIELD,
    DFC_C_HDR_MATCH,
    DFC_C_NOT_FOUND,
    DFC_C_NO_SYNC,
    DFC_C_OVERRUN,
    DFC_C_WR_HDR_UNREAD,
    DFC_C_ST_RAM,
    DFC_C_ST_COMPARE,
    DFC_C_ST_RETRY,
    DFC_C_ST_ECC,
    DFC_C_PON_NO_SEL,
    DFC_C_PON_CMD_TMO,
    DFC_C_PON_ILLEGAL,
    DFC_C_PON_NOT_RDY,
    DFC_C_AUTOCFG,
    DFC_C_PON_ATN_RST,
    DFC_C_VENDOR,
    DFC_C_MECH,
    DFC_C_SEEK_DIAG,
    DFC_C_LOSS_RETRY,
    DFC_C_OFS_LOST,
    DFC_C_SEEK_LOST,
    DFC_C_HDR_TMO,
    DFC_C_FULL_SECT,
    DFC_C_CTRL_FATAL,
    DFC_C_RETRY_FMT,
    DFC_C_RETRY_VFY,
    DFC_C_RETRY_HDR,
    DFC_C_SAVE_INFO,
    DFC_C_SPARE_TMO,
    DFC_C_RETRY_TMO
  } dfc_cause_t;

endpackage : dfc_pkg

// ---- src/dfc_reporter.sv ----
// dfc_reporter: maps detected drive conditions to an 8-bit code and loads the status bytes
// assumes ahb-lite single word transfers, async drive pins and one 40 MHz clock
//
// Behaviour
// - read data field: 20 marginal, 21 corrected, 22 uncorrectable.
// - read header-fail-with-sector-match: 23 marginal, 24 unrecoverable.
// - read not-found 25/26, no sync 27/28, overrun 29/2A.
// - write blocked by unreadable header reports 2F.
// - write pairs 33/34, 35/36, 37/38, 39/3A, marginal first.
// - self test: fault log, code, drive status, vendor low byte.
// - self test codes 41 ram, 42 compare, 43 retries, 44 ecc.
// - power on codes 45, 46 after 30 s wait, 47, 48.
// - codes 49, 4B, 4C, 4D, 4E for config, attention, vendor, mechanism, seek.
// - controller fault: fault log, code only; 52 read, 53 write loss retry.
// - position unknown: 54 after offset, 55 after seek recovery.
// - compressed drive status bits 0..7 in documented order.
// - controller-chip fault: code, chip status, chip error register.
// - 60 header timeout, 61 full sector, 62/63 chip fatal read/write.
// - retries exhausted: 64 format, 65 verify init, 66 header read.
// - code 67 internal only, never sets a status bit.
// - sparing timeouts 68 header, 69 dealloc, 6A flag, 6B before write.
// - retries out after timeout: 6C format, 6D header, 6E verify.
// - media data errors make run log entry, code only.
//
// The register offsets and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
module dfc_reporter
  import dfc_pkg::*;
#(
  parameter longint PON_WAIT_CYC = DFC_PON_WAIT_CYC
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  input wire logic I_WRITE_FAULT,
  input wire logic I_OFFSET_FAULT,
  input wire logic I_SEEK_FAULT,
  input wire logic I_INVALID_CMD,
  input wire logic I_IFACE_FAULT,
  input wire logic I_PARITY_FAULT,
  input wire logic I_POWER_ON_CONDITION,
  input wire logic I_SPINDLE_STOPPED,
  input wire logic I_DRIVE_SELECTED,
  input wire logic I_CMD_COMPLETE,
  input wire logic I_DRIVE_READY,
  input wire logic I_PON_START,
  input wire logic [7:0] I_VENDOR_STATUS,
  input wire logic [7:0] I_CTRL_STATUS,
  input wire logic [7:0] I_CTRL_ERROR,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  output logic [7:0] O_STATUS_BYTE_CODE,
  output logic [7:0] O_STATUS_BYTE_AUX_A,
  output logic [7:0] O_STATUS_BYTE_AUX_B,
  output logic [1:0] O_LOG_KIND,
  output logic O_LOG_PULSE,
  output logic O_REPORT_VALID
);

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [1:0] {
    DFC_PON_IDLE,
    DFC_PON_WAIT,
    DFC_PON_DONE
  } dfc_pon_t;

  typedef struct packed {
    logic [7:0] drv_meta;
    logic [7:0] drv_sync;
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic [7:0] vend_meta;
    logic [7:0] vend_sync;
    logic [15:0] ctrl_meta;
    logic [15:0] ctrl_sync;
    logic bus_pend;
    logic bus_wr;
    logic [7:0] bus_addr;
    logic [10:0] cause;
    logic [7:0] code;
    logic [7:0] aux_a;
    logic [7:0] aux_b;
    logic [1:0] log_kind;
    logic log_pulse;
    logic valid;
    logic [7:0] saved_info;
    logic [31:0] rdata;
    dfc_pon_t power_on_condition;
    logic [41:0] pon_cnt;
  } dfc_state_t;

  dfc_state_t r;
  dfc_state_t next_r;

  logic [31:0] hw_rd;
  logic [7:0] drv_status;
  logic [7:0] pcode;
  logic pfire;
  logic [7:0] hcode;
  logic hfire;

  // ****************************************
  // code mapping
  // ****************************************
  function automatic logic [7:0] map_code(input logic [4:0] c, input logic wr,
                                          input logic unrec, input logic corr);
    logic [7:0] m;
    m = 8'h00;
    case (dfc_cause_t'(c))
      DFC_C_DATA_FIELD: m = unrec ? 8'h22 : (corr ? 8'h21 : 8'h20);
      DFC_C_HDR_MATCH: m = (wr ? 8'h33 : 8'h23) + {7'h00, unrec};
      DFC_C_NOT_FOUND: m = (wr ? 8'h35 : 8'h25) + {7'h00, unrec};
      DFC_C_NO_SYNC: m = (wr ? 8'h37 : 8'h27) + {7'h00, unrec};
      DFC_C_OVERRUN: m = (wr ? 8'h39 : 8'h29) + {7'h00, unrec};
      DFC_C_WR_HDR_UNREAD: m = 8'h2F;
      DFC_C_ST_RAM: m = 8'h41;
      DFC_C_ST_COMPARE: m = 8'h42;
      DFC_C_ST_RETRY: m = 8'h43;
      DFC_C_ST_ECC: m = 8'h44;
      DFC_C_PON_NO_SEL: m = 8'h45;
      DFC_C_PON_CMD_TMO: m = 8'h46;
      DFC_C_PON_ILLEGAL: m = 8'h47;
      DFC_C_PON_NOT_RDY: m = 8'h48;
      DFC_C_AUTOCFG: m = 8'h49;
      DFC_C_PON_ATN_RST: m = 8'h4B;
      DFC_C_VENDOR: m = 8'h4C;
      DFC_C_MECH: m = 8'h4D;
      DFC_C_SEEK_DIAG: m = 8'h4E;
      DFC_C_LOSS_RETRY: m = wr ? 8'h53 : 8'h52;
      DFC_C_OFS_LOST: m = 8'h54;
      DFC_C_SEEK_LOST: m = 8'h55;
      DFC_C_HDR_TMO: m = 8'h60;
      DFC_C_FULL_SECT: m = 8'h61;
      DFC_C_CTRL_FATAL: m = wr ? 8'h63 : 8'h62;
      DFC_C_RETRY_FMT: m = 8'h64;
      DFC_C_RETRY_VFY: m = 8'h65;
      DFC_C_RETRY_HDR: m = 8'h66;
      DFC_C_SAVE_INFO: m = 8'h67;
      DFC_C_SPARE_TMO: m = 8'h68 + {6'h00, wr, corr};
      DFC_C_RETRY_TMO: m = 8'h6C + {6'h00, wr, corr};
      default: m = 8'h00;
    endcase
    return m;
  endfunction : map_code

  // ****************************************
  // combinational helpers
  // ****************************************
  always_comb begin
    drv_status = r.drv_sync;
    hw_rd = 32'h00000000;
    case (I_HADDR[7:0])
      DFC_REG_EVENT: hw_rd = {5'h00, r.valid, r.log_kind, r.aux_b, r.aux_a, r.code};
      DFC_REG_CAUSE: hw_rd = {21'h000000, r.cause};
      DFC_REG_AUX: hw_rd = {24'h000000, r.saved_info};
      DFC_REG_STATUS: hw_rd = {r.ctrl_sync, r.vend_sync, drv_status};
      DFC_REG_DRVSTAT: hw_rd = {24'h000000, drv_status};
      default: hw_rd = 32'h00000000;
    endcase
    pcode = 8'h00;
    pfire = 1'b0;
    // power-on watchdog: codes are raised by hardware when power on sequencing fails
    if (r.power_on_condition == DFC_PON_WAIT && r.pin_sync[1]) begin
      pfire = 1'b1;
      pcode = r.drv_sync[7:0] == 8'hFF ? map_code(5'(DFC_C_PON_ILLEGAL), 1'b0, 1'b0, 1'b0)
            : (r.pin_sync[2] ? 8'h00 : map_code(5'(DFC_C_PON_NOT_RDY), 1'b0, 1'b0, 1'b0));
      pfire = pcode != 8'h00;
    end else if (r.power_on_condition == DFC_PON_WAIT && !r.pin_sync[0]) begin
      pfire = 1'b1;
      pcode = map_code(5'(DFC_C_PON_NO_SEL), 1'b0, 1'b0, 1'b0);
    end else if (r.power_on_condition == DFC_PON_WAIT && r.pon_cnt >= 42'(PON_WAIT_CYC - 1)) begin
      pfire = 1'b1;
      pcode = map_code(5'(DFC_C_PON_CMD_TMO), 1'b0, 1'b0, 1'b0);
    end
    hfire = r.bus_pend && r.bus_wr && r.bus_addr == DFC_REG_CAUSE && I_HWDATA[DFC_FIRE_BIT];
    hcode = map_code(I_HWDATA[4:0], I_HWDATA[DFC_OP_WRITE_BIT], I_HWDATA[DFC_UNRECOV_BIT],
                     I_HWDATA[DFC_CORRECTED_BIT]);
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [7:0] code;
    logic [4:0] cls;
    logic ack;
    code = 8'h00;
    cls = 5'h00;
    ack = 1'b0;
    next_r = r;
    next_r.log_pulse = 1'b0;
    next_r.drv_meta = {I_SPINDLE_STOPPED, I_POWER_ON_CONDITION, I_PARITY_FAULT, I_IFACE_FAULT,
                       I_INVALID_CMD, I_SEEK_FAULT, I_OFFSET_FAULT, I_WRITE_FAULT};
    next_r.drv_sync = r.drv_meta;
    next_r.pin_meta = {I_DRIVE_READY, I_CMD_COMPLETE, I_DRIVE_SELECTED};
    next_r.pin_sync = r.pin_meta;
    next_r.vend_meta = I_VENDOR_STATUS;
    next_r.vend_sync = r.vend_meta;
    next_r.ctrl_meta = {I_CTRL_ERROR, I_CTRL_STATUS};
    next_r.ctrl_sync = r.ctrl_meta;
    // ahb address phase capture
    if (I_HREADY) begin
      next_r.bus_pend = I_HSEL && I_HTRANS[1];
      next_r.bus_wr = I_HWRITE;
      next_r.bus_addr = I_HADDR[7:0];
    end
    // read data loaded at the address phase so it stands through the data phase
    if (I_HREADY && I_HSEL && I_HTRANS[1] && !I_HWRITE) begin
      next_r.rdata = hw_rd;
    end
    // host acknowledge releases the held report
    ack = r.bus_pend && r.bus_wr && r.bus_addr == DFC_REG_ACK && I_HWDATA[DFC_ACK_BIT];
    if (ack) begin
      next_r.valid = 1'b0;
    end
    // power-on sequencer
    case (r.power_on_condition)
      DFC_PON_IDLE: if (I_PON_START) next_r.power_on_condition = DFC_PON_WAIT;
      DFC_PON_WAIT: begin
        next_r.pon_cnt = r.pon_cnt + 42'h1;
        if (pfire || r.pin_sync[1]) next_r.power_on_condition = DFC_PON_DONE;
      end
      DFC_PON_DONE: next_r.power_on_condition = DFC_PON_DONE;
      default: next_r.power_on_condition = DFC_PON_IDLE;
    endcase
    // hardware detection beats a software cause in the same cycle
    if (pfire) begin
      code = pcode;
    end else if (hfire) begin
      code = hcode;
      next_r.cause = I_HWDATA[10:0];
    end
    cls = code[7:3];
    if (code == 8'h67) begin
      // internal save of drive info, no report change
      next_r.saved_info = drv_status;
    end else if (code != 8'h00 && (!r.valid || ack)) begin
      // a new report wins over an ack in the same cycle
      // a new report cannot overwrite one the host has not acknowledged yet
      next_r.code = code;
      next_r.valid = 1'b1;
      next_r.log_pulse = 1'b1;
      next_r.aux_a = 8'h00;
      next_r.aux_b = 8'h00;
      if (code[7:4] == 4'h2 || code[7:4] == 4'h3) begin
        next_r.log_kind = 2'(DFC_LOG_RUN);
      end else if (code[7:4] == 4'h4) begin
        next_r.log_kind = 2'(DFC_LOG_FAULT);
        next_r.aux_a = drv_status;
        next_r.aux_b = r.vend_sync;
      end else if (code[7:4] == 4'h6) begin
        next_r.log_kind = 2'(DFC_LOG_FAULT);
        next_r.aux_a = r.ctrl_sync[7:0];
        next_r.aux_b = r.ctrl_sync[15:8];
      end else begin
        next_r.log_kind = 2'(DFC_LOG_FAULT);
      end
    end
    if (cls == 5'h1F) begin
      next_r.log_kind = r.log_kind;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign O_HRDATA = r.rdata;
  assign O_HREADYOUT = ~r.bus_pend | r.bus_wr | 1'b1;
  assign O_HRESP = 1'b0;
  assign O_STATUS_BYTE_CODE = r.code;
  assign O_STATUS_BYTE_AUX_A = r.aux_a;
  assign O_STATUS_BYTE_AUX_B = r.aux_b;
  assign O_LOG_KIND = r.log_kind;
  assign O_LOG_PULSE = r.log_pulse;
  assign O_REPORT_VALID = r.valid;

endmodule : dfc_reporter

// ---- tb/dfc_host_model.sv ----
// dfc_host_model: host bus master that loads causes and reads the status bytes
// assumes one slave whose hreadyout is looped back as hready
`timescale 1ns/1ps
module dfc_host_model (
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // ****************************************
  // single word transfer
  // ****************************************
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // read data is taken at the edge that ends the data phase
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
endmodule : dfc_host_model

// ---- tb/dfc_reporter_props.sv ----
// dfc_reporter_props: port-level assertions for the fault code reporter
// assumes one clock domain and the async active-high reset of the top module
`timescale 1ns/1ps
module dfc_reporter_props
  import dfc_pkg::*;
(
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  input wire logic O_HREADYOUT,
  input wire logic O_HRESP,
  input wire logic [7:0] O_STATUS_BYTE_CODE,
  input wire logic [7:0] O_STATUS_BYTE_AUX_A,
  input wire logic [7:0] O_STATUS_BYTE_AUX_B,
  input wire logic [1:0] O_LOG_KIND,
  input wire logic O_LOG_PULSE,
  input wire logic O_REPORT_VALID
);
  // ****************************************
  // helper: ack write taken in address phase
  // ****************************************
  logic ack_wr;
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      ack_wr <= 1'b0;
    end else begin
      ack_wr <= I_HSEL && I_HTRANS[1] && I_HWRITE && I_HREADY && I_HADDR[7:0] == DFC_REG_ACK;
    end
  end
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  // ****************************************
  // assertions
  // ****************************************
  bus_okay_a:
    assert property (O_HREADYOUT && !O_HRESP) else $error("bus not ready or not okay");
  pulse_loads_a:
    assert property (O_LOG_PULSE |-> O_REPORT_VALID && O_LOG_KIND != 2'h0)
    else $error("log pulse without a held report");
  report_held_a:
    assert property (O_REPORT_VALID && !O_LOG_PULSE |-> $stable({O_STATUS_BYTE_CODE,
      O_STATUS_BYTE_AUX_A, O_STATUS_BYTE_AUX_B, O_LOG_KIND})) else $error("report changed");
  pulse_single_a:
    assert property (O_LOG_PULSE |=> !O_LOG_PULSE) else $error("log pulse too long");
  valid_rise_a:
    assert property ($rose(O_REPORT_VALID) |-> O_LOG_PULSE) else $error("valid without pulse");
  media_run_a:
    assert property (O_LOG_PULSE && O_STATUS_BYTE_CODE inside {[8'h20:8'h3A]} |->
      O_LOG_KIND == DFC_LOG_RUN && {O_STATUS_BYTE_AUX_A, O_STATUS_BYTE_AUX_B} == 16'h0000)
    else $error("media error not a plain run entry");
  fault_log_a:
    assert property (O_LOG_PULSE && O_STATUS_BYTE_CODE inside {[8'h41:8'h6E]} |->
      O_LOG_KIND == DFC_LOG_FAULT) else $error("fault code not in fault log");
  no_internal_a:
    assert property (O_REPORT_VALID |-> O_STATUS_BYTE_CODE != 8'h67)
    else $error("internal code reported");
  ack_clears_a:
    assert property (ack_wr && I_HWDATA[0] |-> ##[1:2] (!O_REPORT_VALID || O_LOG_PULSE))
    else $error("ack did not clear report");
  run_seen_c: cover property (O_LOG_PULSE && O_LOG_KIND == DFC_LOG_RUN);
  fault_seen_c: cover property (O_LOG_PULSE && O_LOG_KIND == DFC_LOG_FAULT);
  ack_seen_c: cover property ($fell(O_REPORT_VALID));
endmodule : dfc_reporter_props

bind dfc_reporter dfc_reporter_props u_props (.I_CORE_CLK, .I_RST, .I_HSEL, .I_HADDR,
  .I_HTRANS, .I_HWRITE, .I_HWDATA, .I_HREADY, .O_HREADYOUT, .O_HRESP, .O_STATUS_BYTE_CODE,
  .O_STATUS_BYTE_AUX_A, .O_STATUS_BYTE_AUX_B, .O_LOG_KIND, .O_LOG_PULSE, .O_REPORT_VALID);

// ---- tb/test_disc_fault_code_reporter.sv ----
// test_disc_fault_code_reporter: self-checking bench for the fault code reporter
// assumes the host model as sole bus master and a shortened power-on wait
`timescale 1ns/1ps
module test_disc_fault_code_reporter
  import dfc_pkg::*;
;
  logic clk, rst, hsel, hwrite, power_on_condition, pulse, valid, rdy, resp, sel, cc, dr;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, kind;
  logic [2:0] hsize;
  logic [7:0] drv, vend, cst, cer, code, aa, ab;
  int err_total, comparisons, cyc;
  dfc_host_model u_host (.clk(clk), .hready(rdy), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  dfc_reporter #(.PON_WAIT_CYC(100)) dut (.I_CORE_CLK(clk), .I_RST(rst), .I_HSEL(hsel),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
    .I_HREADY(rdy), .I_WRITE_FAULT(drv[0]), .I_OFFSET_FAULT(drv[1]), .I_SEEK_FAULT(drv[2]),
    .I_INVALID_CMD(drv[3]), .I_IFACE_FAULT(drv[4]), .I_PARITY_FAULT(drv[5]),
    .I_POWER_ON_CONDITION(drv[6]), .I_SPINDLE_STOPPED(drv[7]), .I_DRIVE_SELECTED(sel),
    .I_CMD_COMPLETE(cc), .I_DRIVE_READY(dr), .I_PON_START(power_on_condition), .I_VENDOR_STATUS(vend),
    .I_CTRL_STATUS(cst), .I_CTRL_ERROR(cer), .O_HRDATA(hrdata), .O_HREADYOUT(rdy),
    .O_HRESP(resp), .O_STATUS_BYTE_CODE(code), .O_STATUS_BYTE_AUX_A(aa),
    .O_STATUS_BYTE_AUX_B(ab), .O_LOG_KIND(kind), .O_LOG_PULSE(pulse), .O_REPORT_VALID(valid));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task automatic wv(input int lim);
    int n;
    n = 0;
    while (valid !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    #1;
  endtask : wv
  // flags are {corrected, unrecoverable, write}; acks the report before returning
  task automatic rep(input logic [4:0] c, input logic [2:0] f, input logic [7:0] x,
                     input logic [1:0] k, input logic [7:0] a, input logic [7:0] b);
    u_host.xfer(1'b1, DFC_REG_CAUSE, {1'b1, 20'h0, f, 3'h0, c}, rd);
    wv(20);
    check("code", code, x);
    check("kind", kind, k);
    check("aux", {aa, ab}, {a, b});
    u_host.xfer(1'b0, DFC_REG_EVENT, 32'h0, rd);
    check("event", rd, {5'h0, 1'b1, k, b, a, x});
    u_host.xfer(1'b1, DFC_REG_ACK, 32'h1, rd);
    #1 check("acked", valid, 1'b0);
  endtask : rep
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_media;
    for (int w = 0; w < 2; w++) begin
      rep(DFC_C_DATA_FIELD, 3'b000, 8'h20, DFC_LOG_RUN, 8'h00, 8'h00);
      for (int i = 0; i < 8; i++) begin
        rep(5'(DFC_C_HDR_MATCH) + 5'(i / 2), {1'b0, i[0], w[0]}, 8'(8'h23 + 16 * w + i),
          DFC_LOG_RUN, 8'h00, 8'h00);
      end
    end
    rep(DFC_C_DATA_FIELD, 3'b100, 8'h21, DFC_LOG_RUN, 8'h00, 8'h00);
    rep(DFC_C_DATA_FIELD, 3'b010, 8'h22, DFC_LOG_RUN, 8'h00, 8'h00);
    rep(DFC_C_WR_HDR_UNREAD, 3'b011, 8'h2F, DFC_LOG_RUN, 8'h00, 8'h00);
  endtask : t_media
  task automatic t_self;
    logic [7:0] st [13] = '{8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48, 8'h49,
      8'h4B, 8'h4C, 8'h4D, 8'h4E};
    for (int i = 0; i < 13; i++) begin
      rep(5'(DFC_C_ST_RAM) + 5'(i), 3'b000, st[i], DFC_LOG_FAULT, drv, vend);
    end
  endtask : t_self
  task automatic t_ctrl;
    rep(DFC_C_LOSS_RETRY, 3'b000, 8'h52, DFC_LOG_FAULT, 8'h00, 8'h00);
    rep(DFC_C_LOSS_RETRY, 3'b001, 8'h53, DFC_LOG_FAULT, 8'h00, 8'h00);
    rep(DFC_C_OFS_LOST, 3'b000, 8'h54, DFC_LOG_FAULT, 8'h00, 8'h00);
    rep(DFC_C_SEEK_LOST, 3'b000, 8'h55, DFC_LOG_FAULT, 8'h00, 8'h00);
  endtask : t_ctrl
  // sparing and timeout offsets ride on flag bits 8 and 10
  task automatic t_chip;
    logic [15:0] t [14] = '{{3'b000, DFC_C_HDR_TMO, 8'h60}, {3'b000, DFC_C_FULL_SECT, 8'h61},
      {3'b000, DFC_C_CTRL_FATAL, 8'h62}, {3'b001, DFC_C_CTRL_FATAL, 8'h63},
      {3'b000, DFC_C_RETRY_FMT, 8'h64}, {3'b000, DFC_C_RETRY_VFY, 8'h65},
      {3'b000, DFC_C_RETRY_HDR, 8'h66}, {3'b000, DFC_C_SPARE_TMO, 8'h68},
      {3'b100, DFC_C_SPARE_TMO, 8'h69}, {3'b001, DFC_C_SPARE_TMO, 8'h6A},
      {3'b101, DFC_C_SPARE_TMO, 8'h6B}, {3'b000, DFC_C_RETRY_TMO, 8'h6C},
      {3'b100, DFC_C_RETRY_TMO, 8'h6D}, {3'b001, DFC_C_RETRY_TMO, 8'h6E}};
    for (int i = 0; i < 14; i++) begin
      rep(t[i][12:8], t[i][15:13], t[i][7:0], DFC_LOG_FAULT, cst, cer);
    end
  endtask : t_chip
  task automatic t_hold;
    u_host.xfer(1'b1, DFC_REG_CAUSE, {24'h800000, 3'h0, DFC_C_SAVE_INFO}, rd);
    repeat (10) @(posedge clk);
    #1 check("internal", valid, 1'b0);
    u_host.xfer(1'b1, DFC_REG_CAUSE, 32'h8000_0000, rd);
    wv(20);
    u_host.xfer(1'b1, DFC_REG_CAUSE, {24'h800002, 3'h0, DFC_C_NOT_FOUND}, rd);
    #1 check("held", {valid, code}, 9'h120);
    u_host.xfer(1'b0, 8'h1C, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    u_host.xfer(1'b0, DFC_REG_AUX, 32'h0, rd);
    check("saved", rd, {24'h0, drv});
    u_host.xfer(1'b0, DFC_REG_STATUS, 32'h0, rd);
    check("status", rd, {cer, cst, vend, drv});
    u_host.xfer(1'b0, DFC_REG_DRVSTAT, 32'h0, rd);
    check("drvstat", rd, {24'h0, drv});
    u_host.xfer(1'b1, DFC_REG_ACK, 32'h1, rd);
  endtask : t_hold
  // the power-on watch runs once, so every case starts from a fresh reset
  task automatic t_pon(input logic s, input logic c, input logic d, input logic [7:0] dv,
                       input logic [7:0] x);
    rst <= 1'b1;
    {sel, cc, dr} <= {s, c, d};
    drv <= dv;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    power_on_condition <= 1'b1;
    @(posedge clk);
    power_on_condition <= 1'b0;
    wv(300);
    check("pon", {kind, code, aa, ab}, {DFC_LOG_FAULT, x, dv, vend});
  endtask : t_pon
  // ****************************************
  // main sequence and timeout
  // ****************************************
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end
  initial begin
    {rst, power_on_condition, sel, cc, dr} = 5'h10;
    {drv, vend, cst, cer} = 32'h1B3C_5AC3;
    {err_total, comparisons, cyc} = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_media();
    t_self();
    t_ctrl();
    t_chip();
    t_hold();
    t_pon(1'b1, 1'b1, 1'b0, drv, 8'h48);
    t_pon(1'b1, 1'b0, 1'b0, drv, 8'h46);
    t_pon(1'b0, 1'b0, 1'b0, drv, 8'h45);
    t_pon(1'b1, 1'b1, 1'b1, 8'hFF, 8'h47);
    final_report();
  end
endmodule : test_disc_fault_code_reporter
